// [src/pcp_parser.sv]
// Control-code interpreter and host-port status of a dot-matrix printer.
// Assumes host pins are asynchronous; the print engine consumes cmd on cmd_ready.
`timescale 1ns/1ps
`default_nettype none
module pcp_parser #(
  parameter int unsigned BUZZ_CYCLES = pcp_pkg::BUZZ_CYC,
  parameter int unsigned ACK_CYCLES = pcp_pkg::ACK_CYC,
  parameter int unsigned PAGE_LINES = pcp_pkg::PAGE_LINES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic strobe_n,
  input wire logic [7:0] data_in,
  input wire logic host_select_input_n,
  input wire logic select_lock_switch,
  input wire logic graphics_variant,
  input wire logic paper_end_in,
  input wire logic offline_in,
  input wire logic error_in,
  input wire logic cmd_ready,
  output logic busy,
  output logic byte_taken_pulse_n,
  output logic fault_n,
  output logic paper_out_flag,
  output logic buzzer,
  output logic cmd_valid,
  output var pcp_pkg::pcp_cmd_s cmd
);
  localparam int MC = pcp_pkg::MAX_COL;

  if (ACK_CYCLES < 1 || ACK_CYCLES > 65535 || PAGE_LINES < 2 || PAGE_LINES > 127 ||
      BUZZ_CYCLES < 1) begin : g_bad_param
    $error("pcp_parser: parameter out of range");
  end

  logic [14:0] sync1_r, sync2_r;
  logic stb_d_r;
  pcp_pkg::pcp_st_e st_r;
  pcp_pkg::pcp_ctx_e ctx_r;
  logic [7:0] byte_r, esc_cmd_r, col_r;
  logic [6:0] line_r;
  logic [15:0] ack_cnt_r;
  logic [31:0] buzz_cnt_r;
  logic [9:0] spacing_r, stored_r;
  logic stored_v_r, dw_r, cond_r, ul_r, dsel_r;
  logic [1:0] init_r;
  logic [MC:0] hstop_r, stage_r, every8;
  logic [127:0] vstop_r;
  pcp_pkg::pcp_cmd_s pend_r, skid_r;
  logic skid_v_r;

  wire stb_s = sync2_r[14];
  wire [7:0] data_s = sync2_r[13:6];
  wire sel_n_s = sync2_r[5];
  wire lock_s = sync2_r[4];
  wire gfx_s = sync2_r[3];
  wire pe_s = sync2_r[2];
  wire off_s = sync2_r[1];
  wire err_s = sync2_r[0];
  wire stb_fall = stb_d_r & ~stb_s;
  wire accept = lock_s | ~sel_n_s;
  wire stall = off_s | err_s | ~accept | (init_r != 2'h0);
  wire take = (st_r == pcp_pkg::S_IDLE) & stb_fall & ~stall;
  wire exec = clk_en & (st_r == pcp_pkg::S_EXEC);
  wire txt = (ctx_r == pcp_pkg::CX_TEXT);
  // Deselected matrix still listens, but only for the reselect code
  wire on = gfx_s | lock_s | dsel_r;
  wire buf_in_ready = ~skid_v_r;
  wire push = (st_r == pcp_pkg::S_PUSH) & buf_in_ready;
  wire [9:0] store_nxt = 10'(pcp_pkg::SP_72_MUL) * 10'(byte_r);
  wire [6:0] line_inc = (line_r == 7'(PAGE_LINES - 1)) ? 7'h00 : line_r + 7'h01;

  logic ht_found, vt_found;
  logic is_lf, emit_w;
  logic [7:0] ht_tgt;
  logic [6:0] vt_tgt;
  always_comb begin
    ht_found = 1'b0;
    ht_tgt = 8'h00;
    vt_found = 1'b0;
    vt_tgt = 7'h00;
    every8 = '0;
    // Descending scan leaves the nearest stop beyond the current position
    for (int i = MC; i >= 1; i--) begin
      every8[i] = (i % pcp_pkg::TAB_PITCH) == 0;
      if (hstop_r[i] && i > int'(col_r)) begin
        ht_found = 1'b1;
        ht_tgt = 8'(i);
      end
    end
    for (int i = 127; i >= 1; i--) begin
      if (vstop_r[i] && i > int'(line_r) && i < int'(PAGE_LINES)) begin
        vt_found = 1'b1;
        vt_tgt = 7'(i);
      end
    end
  end

  function automatic pcp_pkg::pcp_cmd_s mk(input pcp_pkg::pcp_op_e op, input logic [9:0] arg);
    // Matrix double width goes out as a line op, never per character
    mk = '{op: op, arg: arg, wide: dw_r & gfx_s, cond: cond_r, uline: ul_r};
  endfunction : mk

  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      stb_d_r <= 1'b0;
    end else if (clk_en) begin
      sync1_r <= {strobe_n, data_in, host_select_input_n, select_lock_switch,
                  graphics_variant, paper_end_in, offline_in, error_in};
      sync2_r <= sync1_r;
      stb_d_r <= stb_s;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      busy <= 1'b1;
      fault_n <= 1'b1;
      paper_out_flag <= 1'b0;
      buzzer <= 1'b0;
    end else if (clk_en) begin
      busy <= stall | (st_r != pcp_pkg::S_IDLE) | take;
      fault_n <= ~(pe_s | off_s | err_s);
      paper_out_flag <= pe_s;
      buzzer <= buzz_cnt_r != 32'h0;
    end
  end

  // Handshake sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= pcp_pkg::S_IDLE;
      byte_r <= 8'h00;
      ack_cnt_r <= 16'h0000;
      byte_taken_pulse_n <= 1'b1;
      init_r <= 2'(pcp_pkg::INIT_CYC);
    end else if (clk_en) begin
      if (init_r != 2'h0) init_r <= init_r - 2'h1;
      case (st_r)
        pcp_pkg::S_IDLE: begin
          if (take) begin
            byte_r <= data_s;
            st_r <= pcp_pkg::S_EXEC;
          end
        end
        pcp_pkg::S_PUSH: begin
          if (push) st_r <= pcp_pkg::S_ACK;
        end
        pcp_pkg::S_ACK: begin
          if (ack_cnt_r == 16'(ACK_CYCLES)) begin
            byte_taken_pulse_n <= 1'b1;
            ack_cnt_r <= 16'h0000;
            st_r <= pcp_pkg::S_IDLE;
          end else begin
            byte_taken_pulse_n <= 1'b0;
            ack_cnt_r <= ack_cnt_r + 16'h0001;
          end
        end
        default: begin
          st_r <= pcp_pkg::S_ACK;
          if (emit_w) st_r <= pcp_pkg::S_PUSH;
        end
      endcase
    end
  end

  // Bytes that hand a command to the engine
  assign is_lf = txt & on & ((byte_r == pcp_pkg::C_LF) |
               ((byte_r == pcp_pkg::C_VT) & (gfx_s | ~vt_found)));
  assign emit_w = txt & on & (is_lf | (byte_r == pcp_pkg::C_VT) | (byte_r == pcp_pkg::C_FF) |
                (byte_r == pcp_pkg::C_CR) | (byte_r == pcp_pkg::C_CAN) |
                ((byte_r == pcp_pkg::C_HT) & ht_found) | ((byte_r == pcp_pkg::C_SO) & ~gfx_s) |
                (byte_r >= pcp_pkg::C_PRINT_MIN));

  // Interpreter state, updated once per taken byte, except the buzzer countdown and start-up tab stops
  always_ff @(posedge clock) begin
    if (rst) begin
      ctx_r <= pcp_pkg::CX_TEXT;
      esc_cmd_r <= 8'h00;
      col_r <= 8'h00;
      line_r <= 7'h00;
      buzz_cnt_r <= 32'h0;
      spacing_r <= pcp_pkg::SP_6;
      stored_r <= pcp_pkg::SP_6;
      {stored_v_r, dw_r, cond_r, ul_r} <= 4'h0;
      dsel_r <= 1'b1;
      hstop_r <= '0;
      stage_r <= '0;
      vstop_r <= '0;
      pend_r <= '0;
    end else if (clk_en) begin
      if (buzz_cnt_r != 32'h0) buzz_cnt_r <= buzz_cnt_r - 32'h1;
      if (init_r == 2'h1 && gfx_s) hstop_r <= every8;
      if (exec) begin
        case (ctx_r)
          pcp_pkg::CX_SEL: begin
            esc_cmd_r <= byte_r;
            ctx_r <= pcp_pkg::CX_TEXT;
            if (byte_r == pcp_pkg::E_STORE ||
                (gfx_s && (byte_r == pcp_pkg::E_ULINE || byte_r == pcp_pkg::E_SP216)))
              ctx_r <= pcp_pkg::CX_PARM;
            else if (byte_r == pcp_pkg::E_SP8) spacing_r <= pcp_pkg::SP_8;
            else if (byte_r == pcp_pkg::E_SP7) spacing_r <= pcp_pkg::SP_7_72;
            else if (byte_r == pcp_pkg::E_SPVAR)
              spacing_r <= stored_v_r ? stored_r : pcp_pkg::SP_6;
            else if (byte_r == pcp_pkg::E_HTABS || byte_r == pcp_pkg::E_VTABS) begin
              stage_r <= '0;
              ctx_r <= (byte_r == pcp_pkg::E_HTABS) ? pcp_pkg::CX_HLIST : pcp_pkg::CX_VLIST;
            end
          end
          pcp_pkg::CX_PARM: begin
            ctx_r <= pcp_pkg::CX_TEXT;
            if (esc_cmd_r == pcp_pkg::E_ULINE) begin
              if (byte_r == pcp_pkg::P_ON) ul_r <= 1'b1;
              else if (byte_r == pcp_pkg::P_OFF) ul_r <= 1'b0;
            end else if (esc_cmd_r == pcp_pkg::E_SP216) begin
              if (byte_r != 8'h00) spacing_r <= {2'h0, byte_r};
            end else if (byte_r != 8'h00) begin
              stored_r <= store_nxt;
              stored_v_r <= 1'b1;
            end
          end
          pcp_pkg::CX_HLIST, pcp_pkg::CX_VLIST: begin
            // New stops take hold only at the terminator
            if (byte_r == pcp_pkg::C_NUL) begin
              ctx_r <= pcp_pkg::CX_TEXT;
              if (ctx_r == pcp_pkg::CX_HLIST) hstop_r <= stage_r;
              else if (!gfx_s) vstop_r <= stage_r[127:0];
            end else if (int'(byte_r) <= MC) begin
              stage_r[byte_r] <= 1'b1;
            end
          end
          default: begin
            if (!on) begin
              if (byte_r == pcp_pkg::C_DC1) dsel_r <= 1'b1;
            end else if (is_lf) begin
              pend_r <= mk(pcp_pkg::OP_FEED, spacing_r);
              line_r <= line_inc;
              dw_r <= 1'b0;
            end else begin
              case (byte_r)
                pcp_pkg::C_BEL: buzz_cnt_r <= BUZZ_CYCLES;
                pcp_pkg::C_HT: begin
                  pend_r <= mk(pcp_pkg::OP_HTAB, {2'h0, ht_tgt});
                  // No stop ahead: the head stays where it is
                  if (ht_found) col_r <= ht_tgt;
                end
                pcp_pkg::C_VT: begin
                  pend_r <= mk(pcp_pkg::OP_VTAB, {3'h0, vt_tgt - line_r});
                  line_r <= vt_tgt;
                end
                pcp_pkg::C_FF: begin
                  pend_r <= mk(pcp_pkg::OP_FORM, 10'(PAGE_LINES) - {3'h0, line_r});
                  line_r <= 7'h00;
                end
                pcp_pkg::C_CR: begin
                  pend_r <= mk(pcp_pkg::OP_PRINT, 10'h000);
                  col_r <= 8'h00;
                  dw_r <= 1'b0;
                end
                pcp_pkg::C_SO: begin
                  dw_r <= 1'b1;
                  pend_r <= mk(pcp_pkg::OP_WIDE_LINE, 10'h000);
                end
                pcp_pkg::C_SI: cond_r <= 1'b1;
                pcp_pkg::C_DC2: cond_r <= 1'b0;
                pcp_pkg::C_DC3: if (!gfx_s && !lock_s) dsel_r <= 1'b0;
                pcp_pkg::C_DC4: dw_r <= 1'b0;
                pcp_pkg::C_CAN: begin
                  pend_r <= mk(pcp_pkg::OP_CLEAR, 10'h000);
                  col_r <= 8'h00;
                  dw_r <= 1'b0;
                end
                pcp_pkg::C_ESC: ctx_r <= pcp_pkg::CX_SEL;
                default: begin
                  if (byte_r >= pcp_pkg::C_PRINT_MIN) begin
                    pend_r <= mk(pcp_pkg::OP_CHAR, {2'h0, byte_r});
                    if (int'(col_r) != MC) col_r <= col_r + 8'h01;
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  // Two-entry output buffer: cmd register plus a skid slot
  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd <= '0;
      skid_v_r <= 1'b0;
      skid_r <= '0;
    end else if (clk_en) begin
      if (cmd_ready || !cmd_valid) begin
        if (skid_v_r) begin
          cmd <= skid_r;
          skid_v_r <= 1'b0;
        end else begin
          cmd_valid <= push;
          if (push) cmd <= pend_r;
        end
      end else if (push) begin
        skid_r <= pend_r;
        skid_v_r <= 1'b1;
      end
    end
  end

  // Checks
  logic [15:0] low_len_r;
  always_ff @(posedge clock) begin
    if (rst) low_len_r <= 16'h0000;
    else if (clk_en) low_len_r <= byte_taken_pulse_n ? 16'h0000 : low_len_r + 16'h0001;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_bel;
    exec && txt && on && byte_r == pcp_pkg::C_BEL;
  endsequence
  sequence s_lf;
    exec && txt && on && byte_r == pcp_pkg::C_LF;
  endsequence

  a_fault_level: assert property (clk_en && (pe_s || off_s || err_s) |=> !fault_n)
    else $error("fault output not low on fault condition");
  a_desel_ignore: assert property (clk_en && st_r == pcp_pkg::S_IDLE && !accept |=>
    st_r == pcp_pkg::S_IDLE)
    else $error("byte taken while not selected");
  a_ack_width: assert property ($rose(byte_taken_pulse_n) |-> low_len_r == 16'(ACK_CYCLES))
    else $error("acknowledge pulse width wrong");
  a_busy_cases: assert property (clk_en && (off_s || err_s || st_r != pcp_pkg::S_IDLE) |=> busy)
    else $error("busy low while unable to take data");
  a_bell_buzz: assert property (s_bel ##1 clk_en |=> buzzer)
    else $error("bell did not start buzzer");
  a_dw_cancel: assert property (s_lf |=> !dw_r && pend_r.op == pcp_pkg::OP_FEED)
    else $error("line feed kept double width");
  a_lf_spacing: assert property (s_lf |=> pend_r.arg == $past(spacing_r))
    else $error("line feed spacing wrong");
  a_vt_gfx: assert property (exec && txt && gfx_s && byte_r == pcp_pkg::C_VT |=>
    pend_r.op == pcp_pkg::OP_FEED)
    else $error("graphics vertical tab not a line feed");
  a_esc_two: assert property (exec && ctx_r == pcp_pkg::CX_SEL && byte_r == pcp_pkg::E_SPVAR &&
    !stored_v_r |=> spacing_r == pcp_pkg::SP_6)
    else $error("escape-two default spacing wrong");
endmodule : pcp_parser
`default_nettype wire

// [src/pcp_pkg.sv]
// Constants, codes and carrier types for the printer control-code parser.
// Assumes a 25 MHz core clock; all users reference names as pcp_pkg::name.
package pcp_pkg;
  localparam int CLK_NS = 40;
  localparam int ACK_NS = 5000;
  localparam int ACK_CYC = ACK_NS / CLK_NS;
  localparam int BUZZ_MS = 1000;
  localparam int BUZZ_CYC = BUZZ_MS * 1000000 / CLK_NS;
  localparam int PAGE_LINES = 66;
  localparam int MAX_COL = 132;
  localparam int TAB_PITCH = 8;
  localparam int INIT_CYC = 3;
  // Control codes
  localparam logic [7:0] C_NUL = 8'h00;
  localparam logic [7:0] C_BEL = 8'h07;
  localparam logic [7:0] C_HT = 8'h09;
  localparam logic [7:0] C_LF = 8'h0A;
  localparam logic [7:0] C_VT = 8'h0B;
  localparam logic [7:0] C_FF = 8'h0C;
  localparam logic [7:0] C_CR = 8'h0D;
  localparam logic [7:0] C_SO = 8'h0E;
  localparam logic [7:0] C_SI = 8'h0F;
  localparam logic [7:0] C_DC1 = 8'h11;
  localparam logic [7:0] C_DC2 = 8'h12;
  localparam logic [7:0] C_DC3 = 8'h13;
  localparam logic [7:0] C_DC4 = 8'h14;
  localparam logic [7:0] C_CAN = 8'h18;
  localparam logic [7:0] C_ESC = 8'h1B;
  localparam logic [7:0] C_PRINT_MIN = 8'h20;
  // Escape selectors
  localparam logic [7:0] E_ULINE = 8'h2D;
  localparam logic [7:0] E_SP8 = 8'h30;
  localparam logic [7:0] E_SP7 = 8'h31;
  localparam logic [7:0] E_SPVAR = 8'h32;
  localparam logic [7:0] E_SP216 = 8'h33;
  localparam logic [7:0] E_STORE = 8'h41;
  localparam logic [7:0] E_VTABS = 8'h42;
  localparam logic [7:0] E_HTABS = 8'h44;
  localparam logic [7:0] P_ON = 8'h01;
  localparam logic [7:0] P_OFF = 8'h00;
  // Line spacing in 1/216 inch
  localparam logic [9:0] SP_6 = 10'h024;
  localparam logic [9:0] SP_8 = 10'h01B;
  localparam logic [9:0] SP_7_72 = 10'h015;
  localparam logic [1:0] SP_72_MUL = 2'h3;
  typedef enum logic [3:0] {
    OP_CHAR, OP_PRINT, OP_FEED, OP_VTAB, OP_FORM, OP_HTAB, OP_CLEAR, OP_WIDE_LINE
  } pcp_op_e;
  typedef struct packed {
    pcp_op_e op;
    logic [9:0] arg;
    logic wide;
    logic cond;
    logic uline;
  } pcp_cmd_s;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_EXEC = 4'h2, S_PUSH = 4'h4, S_ACK = 4'h8
  } pcp_st_e;
  typedef enum logic [4:0] {
    CX_TEXT = 5'h01, CX_SEL = 5'h02, CX_PARM = 5'h04, CX_HLIST = 5'h08, CX_VLIST = 5'h10
  } pcp_ctx_e;
endpackage : pcp_pkg

// [verification/pcp_host_model.sv]
// Host-side parallel adapter model: drives strobe and data, keeps the handshake.
// Assumes the printer answers with busy and an active-low acknowledge on clock.
`timescale 1ns/1ps
`default_nettype none
module pcp_host_model (
  input wire logic clock,
  input wire logic busy,
  input wire logic byte_taken_pulse_n,
  output logic strobe_n,
  output logic [7:0] data_in
);
  initial begin
    strobe_n = 1'b1;
    data_in = 8'hFF;
  end

  // Strobe stays low until acknowledge is seen and 0.5 us has passed
  task automatic send(input logic [7:0] b, output logic ok);
    int n;
    logic seen;
    ok = 1'b0;
    seen = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 2000) return;
    data_in = b;
    @(posedge clock);
    #1;
    strobe_n = 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      seen = seen | (byte_taken_pulse_n === 1'b0);
    end while ((!seen || n < 13) && n < 2000);
    #1;
    strobe_n = 1'b1;
    // Released lines must not keep showing the byte
    data_in = ~b;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    ok = seen && (n < 2000);
  endtask : send
endmodule : pcp_host_model
`default_nettype wire

// [verification/printer_control_code_parser_tb.sv]
// Self-checking bench for the control-code parser: byte table, then edge cases.
// Assumes package and parser compiled first; short ack and buzzer counts.
`timescale 1ns/1ps
`default_nettype none
module printer_control_code_parser_tb;
  localparam int ACK_SIM = 4;
  localparam int BUZZ_SIM = 50;
  typedef struct packed {
    logic gv; logic [7:0] b; logic has; pcp_pkg::pcp_op_e op;
    logic [9:0] arg; logic full; logic [2:0] fl;
  } pcp_row_s;
  logic clock, rst, host_select_input_n, select_lock_switch, graphics_variant;
  logic paper_end_in, offline_in, error_in, cmd_ready, clk_en;
  logic busy, byte_taken_pulse_n, fault_n, paper_out_flag, buzzer, cmd_valid, ok, gv_now;
  wire logic strobe_n;
  wire logic [7:0] data_in;
  pcp_pkg::pcp_cmd_s cmd, c;
  pcp_pkg::pcp_cmd_s got[$];
  pcp_row_s rows[$];
  int miscompares = 0;
  int checks_done = 0;
  int ack_len = 0;
  int buz_len = 0;

  pcp_parser #(.BUZZ_CYCLES(BUZZ_SIM), .ACK_CYCLES(ACK_SIM),
    .PAGE_LINES(pcp_pkg::PAGE_LINES)) dut (.clock(clock), .rst(rst), .clk_en(clk_en),
    .strobe_n(strobe_n), .data_in(data_in), .host_select_input_n(host_select_input_n),
    .select_lock_switch(select_lock_switch), .graphics_variant(graphics_variant),
    .paper_end_in(paper_end_in), .offline_in(offline_in), .error_in(error_in),
    .cmd_ready(cmd_ready), .busy(busy), .byte_taken_pulse_n(byte_taken_pulse_n),
    .fault_n(fault_n), .paper_out_flag(paper_out_flag), .buzzer(buzzer),
    .cmd_valid(cmd_valid), .cmd(cmd));
  pcp_host_model host (.clock(clock), .busy(busy), .byte_taken_pulse_n(byte_taken_pulse_n),
    .strobe_n(strobe_n), .data_in(data_in));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (exp !== seen) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic xfer(input logic [7:0] b);
    host.send(b, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] handshake expected 1 seen %b", ok);
      wrap_up();
    end
    step(2);
  endtask : xfer

  task automatic do_reset(input logic gv);
    rst = 1'b1;
    graphics_variant = gv;
    step(8);
    chk("reset busy", 16'h1, 16'(busy));
    chk("reset ack", 16'h1, 16'(byte_taken_pulse_n));
    chk("reset valid", 16'h0, 16'(cmd_valid));
    rst = 1'b0;
    step(12);
    got.delete();
  endtask : do_reset

  task automatic ch(input logic [7:0] b, input logic [2:0] fl);
    rows.push_back('{gv_now, b, 1'b1, pcp_pkg::OP_CHAR, {2'h0, b}, 1'b1, fl});
  endtask : ch
  task automatic nc(input logic [7:0] b);
    rows.push_back('{gv_now, b, 1'b0, pcp_pkg::OP_CHAR, 10'h000, 1'b0, 3'h0});
  endtask : nc
  task automatic cm(input logic [7:0] b, input pcp_pkg::pcp_op_e op, input logic [9:0] a,
      input logic full);
    rows.push_back('{gv_now, b, 1'b1, op, a, full, 3'h0});
  endtask : cm

  // Commands taken by the engine, plus pulse width meters
  always @(posedge clock) begin
    if (!rst && cmd_valid === 1'b1 && cmd_ready === 1'b1) got.push_back(cmd);
    if (rst) ack_len = 0;
    else if (byte_taken_pulse_n === 1'b0) ack_len++;
    else if (ack_len != 0) begin
      chk("ack width", 16'(ACK_SIM), 16'(ack_len));
      ack_len = 0;
    end
    if (rst) buz_len = 0;
    else if (buzzer === 1'b1) buz_len++;
    else if (buz_len != 0) begin
      chk("buzzer width", 16'(BUZZ_SIM), 16'(buz_len));
      buz_len = 0;
    end
  end

  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    $display("[FAIL] run end expected done seen timeout");
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    {host_select_input_n, select_lock_switch, graphics_variant} = 3'h0;
    {paper_end_in, offline_in, error_in} = 3'h0;
    cmd_ready = 1'b1;
    clk_en = 1'b1;
    gv_now = 1'b1;
    nc(pcp_pkg::C_BEL);
    ch(8'h41, 3'h0);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_SP8); cm(pcp_pkg::C_LF, pcp_pkg::OP_FEED, pcp_pkg::SP_8, 1);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_SP7); cm(pcp_pkg::C_LF, pcp_pkg::OP_FEED, pcp_pkg::SP_7_72, 1);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_STORE); nc(8'h08); cm(pcp_pkg::C_LF, pcp_pkg::OP_FEED, pcp_pkg::SP_7_72, 1);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_SPVAR); cm(pcp_pkg::C_LF, pcp_pkg::OP_FEED, 10'h018, 1);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_SP216); nc(8'h36); cm(pcp_pkg::C_LF, pcp_pkg::OP_FEED, 10'h036, 1);
    cm(pcp_pkg::C_VT, pcp_pkg::OP_FEED, 10'h036, 1);
    nc(pcp_pkg::C_ESC); nc(8'h5A); ch(8'h4A, 3'h0);
    nc(pcp_pkg::C_SI); ch(8'h42, 3'h2); nc(pcp_pkg::C_DC2); ch(8'h43, 3'h0);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_ULINE); nc(pcp_pkg::P_ON); ch(8'h46, 3'h1);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_ULINE); nc(pcp_pkg::P_OFF); ch(8'h47, 3'h0);
    nc(pcp_pkg::C_SO); ch(8'h44, 3'h4); cm(pcp_pkg::C_LF, pcp_pkg::OP_FEED, 10'h036, 0); ch(8'h45, 3'h0);
    nc(pcp_pkg::C_SO); nc(pcp_pkg::C_DC4); ch(8'h48, 3'h0);
    nc(pcp_pkg::C_SO); cm(pcp_pkg::C_CAN, pcp_pkg::OP_CLEAR, 10'h000, 0); ch(8'h49, 3'h0);
    nc(pcp_pkg::C_SO); cm(pcp_pkg::C_CR, pcp_pkg::OP_PRINT, 10'h000, 0);
    cm(pcp_pkg::C_HT, pcp_pkg::OP_HTAB, 10'h008, 0); cm(pcp_pkg::C_HT, pcp_pkg::OP_HTAB, 10'h010, 0);
    ch(8'h50, 3'h0); nc(pcp_pkg::C_DC3); ch(8'h51, 3'h0);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_HTABS); nc(8'h05); nc(pcp_pkg::C_NUL);
    cm(pcp_pkg::C_CR, pcp_pkg::OP_PRINT, 10'h000, 0); cm(pcp_pkg::C_HT, pcp_pkg::OP_HTAB, 10'h005, 0);
    cm(pcp_pkg::C_FF, pcp_pkg::OP_FORM, 10'h000, 0);
    cm(pcp_pkg::C_FF, pcp_pkg::OP_FORM, 10'(pcp_pkg::PAGE_LINES), 1);
    gv_now = 1'b0;
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_SPVAR); cm(pcp_pkg::C_LF, pcp_pkg::OP_FEED, pcp_pkg::SP_6, 1);
    cm(pcp_pkg::C_VT, pcp_pkg::OP_FEED, pcp_pkg::SP_6, 1);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_ULINE); ch(8'h4B, 3'h0);
    cm(pcp_pkg::C_SO, pcp_pkg::OP_WIDE_LINE, 10'h000, 0); ch(8'h4C, 3'h0);
    nc(pcp_pkg::C_HT); ch(8'h4D, 3'h0);
    nc(pcp_pkg::C_DC3); nc(8'h4E); nc(pcp_pkg::C_DC1); ch(8'h4F, 3'h0);
    nc(pcp_pkg::C_ESC); nc(pcp_pkg::E_VTABS); nc(8'h05); nc(pcp_pkg::C_NUL);
    cm(pcp_pkg::C_VT, pcp_pkg::OP_VTAB, 10'h003, 1);
    foreach (rows[i]) begin
      if (i == 0 || rows[i].gv !== rows[i - 1].gv) do_reset(rows[i].gv);
      xfer(rows[i].b);
      chk("cmd count", 16'(rows[i].has), 16'(got.size()));
      if (rows[i].has && got.size() != 0) begin
        c = got.pop_front();
        chk("cmd op", 16'(rows[i].op), 16'(c.op));
        if (rows[i].full) begin
          chk("cmd arg", 16'(rows[i].arg), 16'(c.arg));
          chk("cmd flags", 16'(rows[i].fl), 16'({c.wide, c.cond, c.uline}));
        end
      end
      got.delete();
    end
    do_reset(1'b1);
    // Enable low must hold every flop, the fault path included
    clk_en = 1'b0;
    offline_in = 1'b1;
    step(8);
    chk("frozen fault_n", 16'h1, 16'(fault_n));
    clk_en = 1'b1;
    offline_in = 1'b0;
    step(8);
    for (int i = 0; i < 3; i++) begin
      {paper_end_in, offline_in, error_in} = 3'h4 >> i;
      step(8);
      chk("fault_n", 16'h0, 16'(fault_n));
      chk("paper flag", 16'(i == 0), 16'(paper_out_flag));
      chk("busy on fault", 16'(i != 0), 16'(busy));
    end
    {paper_end_in, offline_in, error_in} = 3'h0;
    step(8);
    chk("fault_n clear", 16'h1, 16'(fault_n));
    xfer(pcp_pkg::C_BEL);
    chk("buzzer on", 16'h1, 16'(buzzer));
    step(60);
    chk("buzzer off", 16'h0, 16'(buzzer));
    host_select_input_n = 1'b1;
    step(8);
    chk("busy unselected", 16'h1, 16'(busy));
    select_lock_switch = 1'b1;
    step(8);
    chk("busy locked", 16'h0, 16'(busy));
    xfer(8'h52);
    chk("locked take", 16'h1, 16'(got.size()));
    got.delete();
    cmd_ready = 1'b0;
    xfer(8'h61);
    xfer(8'h62);
    fork
      xfer(8'h63);
      begin
        step(40);
        chk("ack while full", 16'h1, 16'(byte_taken_pulse_n));
        chk("busy while full", 16'h1, 16'(busy));
        cmd_ready = 1'b1;
      end
    join
    step(4);
    chk("drained", 16'h3, 16'(got.size()));
    for (int k = 0; k < 3 && got.size() != 0; k++) begin
      c = got.pop_front();
      chk("order", 16'(8'h61 + k), 16'(c.arg));
    end
    wrap_up();
  end
endmodule : printer_control_code_parser_tb
`default_nettype wire
